/* hw/dbc_pkg.sv */
package dbc_pkg;

  localparam int unsigned BP_W   = 16;
  localparam int unsigned NBP    = 6;
  localparam int unsigned NPC    = 4;
  localparam int unsigned IR_W   = 3;
  localparam int unsigned DR_W   = 10;

  localparam logic [BP_W-1:0] BP_RESET   = 16'hFFFF;
  localparam logic [BP_W-1:0] DEBUG_ADDRESS_MASK_REGISTER_RESET = 16'h0000;
  localparam logic [BP_W-1:0] DEBUG_DATA_REGISTER_RESET = 16'h0000;
  localparam logic [7:0]      DEBUG_CONTROL_REGISTER_RESET = 8'h00;

  // Control byte layout.
  localparam int unsigned DEBUG_CONTROL_REGISTER_DME_BIT  = 5;
  localparam int unsigned DEBUG_CONTROL_REGISTER_REGISTER_BREAK_SELECT_BIT = 3;

  // Register breakpoint field layout.
  localparam int unsigned REG_MOD_MSB = 3;
  localparam int unsigned REG_IDX_MSB = 8;

  // Shift word layout: status in the low bits, byte above.
  localparam int unsigned DR_ST_MSB  = 1;
  localparam int unsigned DR_DAT_LSB = 2;

  localparam logic [1:0] ST_NONDEBUG = 2'h0;
  localparam logic [1:0] ST_DBG_IDLE = 2'h1;

  localparam logic [IR_W-1:0] IR_DEBUG   = 3'h2;
  localparam logic [IR_W-1:0] IR_RESET   = 3'h7;
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

  localparam logic [7:0] OP_RD_DEBUG_CONTROL_REGISTER = 8'h01;
  localparam logic [7:0] OP_RD_DEBUG_ADDRESS_MASK_REGISTER = 8'h03;
  localparam logic [7:0] OP_RD_DEBUG_DATA_REGISTER = 8'h04;
  localparam logic [7:0] OP_RD_BP0  = 8'h05;
  localparam logic [7:0] OP_WR_DEBUG_CONTROL_REGISTER = 8'h11;
  localparam logic [7:0] OP_WR_DEBUG_ADDRESS_MASK_REGISTER = 8'h13;
  localparam logic [7:0] OP_WR_DEBUG_DATA_REGISTER = 8'h14;
  localparam logic [7:0] OP_WR_BP0  = 8'h15;
  localparam logic [7:0] OP_DEBUG   = 8'h1F;

  typedef enum logic [15:0] {
    TAP_TLR    = 16'h0001,
    TAP_RTI    = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SH_DR  = 16'h0010,
    TAP_EX1_DR = 16'h0020,
    TAP_PAU_DR = 16'h0040,
    TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SH_IR  = 16'h0800,
    TAP_EX1_IR = 16'h1000,
    TAP_PAU_IR = 16'h2000,
    TAP_EX2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } dbc_tap_e;

  typedef enum logic [2:0] {
    CMD_IDLE = 3'h1,
    CMD_LO   = 3'h2,
    CMD_HI   = 3'h4
  } dbc_cmd_e;

endpackage

/* hw/dbc_tap_fsm.sv */
`timescale 1ns/100ps
`default_nettype none
module dbc_tap_fsm (
  input  wire logic             ref_clk_i, // System clock.
  input  wire logic             sys_rst_i, // Asynchronous reset.
  input  wire logic             step_i,    // Link clock rising edge seen.
  input  wire logic             tms_i,     // Synchronised mode select.
  output var dbc_pkg::dbc_tap_e state_o    // Controller state.
);
  import dbc_pkg::*;

  dbc_tap_e state_d;

  always_comb begin
    state_d = state_o;
    unique case (state_o)
      TAP_TLR:    state_d = tms_i ? TAP_TLR    : TAP_RTI;
      TAP_RTI:    state_d = tms_i ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: state_d = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: state_d = tms_i ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  state_d = tms_i ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: state_d = tms_i ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: state_d = tms_i ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: state_d = tms_i ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: state_d = tms_i ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: state_d = tms_i ? TAP_TLR    : TAP_CAP_IR;
      TAP_CAP_IR: state_d = tms_i ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  state_d = tms_i ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: state_d = tms_i ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: state_d = tms_i ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: state_d = tms_i ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: state_d = tms_i ? TAP_SEL_DR : TAP_RTI;
      default:    state_d = TAP_TLR;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_o <= TAP_TLR;
    end else if (step_i) begin
      state_o <= state_d;
    end
  end

endmodule
`default_nettype wire

/* hw/dbc_top.sv */
`timescale 1ns/100ps
`default_nettype none
module dbc_top (
  input  wire logic                     ref_clk_i,    // System clock.
  input  wire logic                     sys_rst_i,    // Async reset.
  input  wire logic                     clk_en_i,     // Freezes state low.
  input  wire logic                     tck_i,        // Link clock pin.
  input  wire logic                     tms_i,        // Link mode pin.
  input  wire logic                     tdi_i,        // Link data in.
  output logic                          tdo_o,        // Link data out.
  input  wire logic                     insn_done_i,  // Instruction retired.
  input  wire logic                     pfx_set_i,    // It loads prefix.
  input  wire logic [dbc_pkg::BP_W-1:0] prog_addr_i,  // Execution address.
  input  wire logic                     dmem_acc_i,   // Data access valid.
  input  wire logic [dbc_pkg::BP_W-1:0] dmem_addr_i,  // Data address.
  input  wire logic                     dst_wr_i,     // Register written.
  input  wire logic [3:0]               dst_mod_i,    // Destination module.
  input  wire logic [4:0]               dst_idx_i,    // Destination index.
  input  wire logic [dbc_pkg::BP_W-1:0] dst_data_i,   // Value written.
  input  wire logic                     dbg_return_i, // Leave debug mode.
  output logic                          debug_mode_o, // Debug mode level.
  output logic                          break_entry_o // Entry pulse.
);
  import dbc_pkg::*;

  // ==========================================================
  // Link pin synchronisers
  // ==========================================================
  logic tck_s1, tms_s1, tdi_s1;
  logic tck_s2, tms_s2, tdi_s2;
  logic tck_s3;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {tck_s1, tms_s1, tdi_s1} <= 3'h0;
      {tck_s2, tms_s2, tdi_s2} <= 3'h0;
      tck_s3                   <= 1'b0;
    end else if (clk_en_i) begin
      {tck_s1, tms_s1, tdi_s1} <= {tck_i, tms_i, tdi_i};
      {tck_s2, tms_s2, tdi_s2} <= {tck_s1, tms_s1, tdi_s1};
      tck_s3                   <= tck_s2;
    end
  end

  logic     tck_rise, tck_fall;
  dbc_tap_e tap_st;

  assign tck_rise = clk_en_i & tck_s2 & ~tck_s3;
  assign tck_fall = clk_en_i & ~tck_s2 & tck_s3;

  dbc_tap_fsm u_tap (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .step_i    (tck_rise),
    .tms_i     (tms_s2),
    .state_o   (tap_st)
  );

  // ==========================================================
  // Instruction and data shift paths
  // ==========================================================
  logic [IR_W-1:0] ir_q, ir_sh_q;
  logic [DR_W-1:0] dr_q;
  logic            byp_q;
  logic [7:0]      tx_q;
  logic            sel_dbg, upd, tlr;
  logic [7:0]      rx;

  assign sel_dbg = (ir_q == IR_DEBUG);
  assign tlr     = tck_rise & (tap_st == TAP_TLR);
  assign upd     = tck_rise & (tap_st == TAP_UPD_DR) & sel_dbg;
  assign rx      = dr_q[DR_W-1:DR_DAT_LSB];

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ir_q    <= IR_RESET;
      ir_sh_q <= IR_CAPTURE;
    end else if (tck_rise) begin
      unique case (tap_st)
        TAP_TLR:    ir_q    <= IR_RESET;
        TAP_CAP_IR: ir_sh_q <= IR_CAPTURE;
        TAP_SH_IR:  ir_sh_q <= {tdi_s2, ir_sh_q[IR_W-1:1]};
        TAP_UPD_IR: ir_q    <= ir_sh_q;
        default:    ir_q    <= ir_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dr_q  <= '0;
      byp_q <= 1'b0;
    end else if (tck_rise && tap_st == TAP_CAP_DR) begin
      dr_q  <= {tx_q, debug_mode_o ? ST_DBG_IDLE : ST_NONDEBUG};
      byp_q <= 1'b0;
    end else if (tck_rise && tap_st == TAP_SH_DR) begin
      if (sel_dbg) begin
        dr_q <= {tdi_s2, dr_q[DR_W-1:1]};
      end else begin
        byp_q <= tdi_s2;
      end
    end
  end

  // Data leaves on the falling link edge so the host samples it stable.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tdo_o <= 1'b0;
    end else if (tck_fall) begin
      if (tap_st == TAP_SH_IR) begin
        tdo_o <= ir_sh_q[0];
      end else if (tap_st == TAP_SH_DR) begin
        tdo_o <= sel_dbg ? dr_q[0] : byp_q;
      end
    end
  end

  // ==========================================================
  // Background command engine
  // ==========================================================
  function automatic logic is_bp(input logic [7:0] op,
                                 input logic [7:0] base);
    is_bp = (op >= base) && (op < base + 8'(NBP));
  endfunction

  function automatic logic [2:0] bp_sel(input logic [7:0] op,
                                        input logic [7:0] base);
    logic [7:0] d;
    d      = op - base;
    bp_sel = d[2:0];
  endfunction

  dbc_cmd_e        cmd_q;
  logic [7:0]      op_q, lo_q, debug_control_register_q, rd_op;
  logic [BP_W-1:0] bp_q [NBP];
  logic [BP_W-1:0] debug_address_mask_register_q, debug_data_register_q, rd_word, wr_word;
  logic            op_wr, wr_fire, dbg_cmd;

  assign rd_op   = (cmd_q == CMD_IDLE) ? rx : op_q;
  assign op_wr   = op_q[4];
  assign wr_word = {rx, lo_q};
  assign wr_fire = upd & (cmd_q == CMD_HI) & op_wr;
  assign dbg_cmd = upd & (cmd_q == CMD_IDLE) & (rx == OP_DEBUG);

  always_comb begin
    rd_word = '0;
    if (is_bp(rd_op, OP_RD_BP0)) begin
      rd_word = bp_q[bp_sel(rd_op, OP_RD_BP0)];
    end else if (rd_op == OP_RD_DEBUG_ADDRESS_MASK_REGISTER) begin
      rd_word = debug_address_mask_register_q;
    end else if (rd_op == OP_RD_DEBUG_DATA_REGISTER) begin
      rd_word = debug_data_register_q;
    end else if (rd_op == OP_RD_DEBUG_CONTROL_REGISTER) begin
      rd_word = {8'h00, debug_control_register_q};
    end
  end

  // Unknown opcodes leave the engine idle, so they act as no operation.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_q <= CMD_IDLE;
      op_q  <= '0;
      lo_q  <= '0;
      tx_q  <= '0;
    end else if (tlr) begin
      cmd_q <= CMD_IDLE;
      tx_q  <= '0;
    end else if (upd) begin
      unique case (cmd_q)
        CMD_IDLE: begin
          op_q <= rx;
          tx_q <= rd_word[7:0];
          if (is_bp(rx, OP_RD_BP0) || is_bp(rx, OP_WR_BP0) ||
              rx == OP_RD_DEBUG_ADDRESS_MASK_REGISTER || rx == OP_RD_DEBUG_DATA_REGISTER ||
              rx == OP_WR_DEBUG_ADDRESS_MASK_REGISTER || rx == OP_WR_DEBUG_DATA_REGISTER ||
              rx == OP_RD_DEBUG_CONTROL_REGISTER || rx == OP_WR_DEBUG_CONTROL_REGISTER) begin
            cmd_q <= CMD_LO;
          end
        end
        CMD_LO: begin
          lo_q <= rx;
          tx_q <= op_wr ? 8'h00 : rd_word[15:8];
          if (op_q == OP_RD_DEBUG_CONTROL_REGISTER || op_q == OP_WR_DEBUG_CONTROL_REGISTER) begin
            cmd_q <= CMD_IDLE;
          end else begin
            cmd_q <= CMD_HI;
          end
        end
        CMD_HI: begin
          tx_q  <= '0;
          cmd_q <= CMD_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Breakpoint and debug registers
  // ==========================================================
  // Only the link engine writes these; the CPU has no path to them.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NBP; i++) begin
        bp_q[i] <= BP_RESET;
      end
    end else if (tlr) begin
      for (int i = 0; i < NBP; i++) begin
        bp_q[i] <= BP_RESET;
      end
    end else if (wr_fire && is_bp(op_q, OP_WR_BP0)) begin
      bp_q[bp_sel(op_q, OP_WR_BP0)] <= wr_word;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      debug_control_register_q <= DEBUG_CONTROL_REGISTER_RESET;
      debug_address_mask_register_q <= DEBUG_ADDRESS_MASK_REGISTER_RESET;
      debug_data_register_q <= DEBUG_DATA_REGISTER_RESET;
    end else if (upd && cmd_q == CMD_LO && op_q == OP_WR_DEBUG_CONTROL_REGISTER) begin
      debug_control_register_q <= rx;
    end else if (wr_fire && op_q == OP_WR_DEBUG_ADDRESS_MASK_REGISTER) begin
      debug_address_mask_register_q <= wr_word;
    end else if (wr_fire && op_q == OP_WR_DEBUG_DATA_REGISTER) begin
      debug_data_register_q <= wr_word;
    end
  end

  // ==========================================================
  // Comparators
  // ==========================================================
  logic            debug_mode_enable_bit, register_break_select, mask_ok;
  logic [NBP-1:0]  hit_vec;
  logic [REG_IDX_MSB:0] dst_reg;

  assign debug_mode_enable_bit     = debug_control_register_q[DEBUG_CONTROL_REGISTER_DME_BIT];
  assign register_break_select    = debug_control_register_q[DEBUG_CONTROL_REGISTER_REGISTER_BREAK_SELECT_BIT];
  assign dst_reg = {dst_idx_i, dst_mod_i};
  // A zero mask compares no bits, so the data term is then always met.
  assign mask_ok = ((dst_data_i ^ debug_data_register_q) & debug_address_mask_register_q) == '0;

  always_comb begin
    hit_vec = '0;
    for (int i = 0; i < NPC; i++) begin
      hit_vec[i] = (prog_addr_i == bp_q[i]);
    end
    for (int i = NPC; i < NBP; i++) begin
      if (register_break_select) begin
        hit_vec[i] = dst_wr_i &&
                     bp_q[i][REG_IDX_MSB:0] == dst_reg;
      end else begin
        hit_vec[i] = dmem_acc_i && bp_q[i] == dmem_addr_i;
      end
    end
    if (register_break_select) begin
      hit_vec[NBP-1] = hit_vec[NBP-1] & mask_ok;
    end
  end

  // ==========================================================
  // Break request and debug mode
  // ==========================================================
  logic hit, pend_q, enter;

  assign hit   = debug_mode_enable_bit & (|hit_vec) & insn_done_i & ~debug_mode_o;
  // A prefixed pair is never split: entry waits for a non-prefix retire.
  assign enter = clk_en_i & insn_done_i & ~pfx_set_i &
                 ~debug_mode_o & (hit | pend_q);

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_q <= 1'b0;
    end else if (clk_en_i) begin
      if (debug_mode_o || enter) begin
        pend_q <= 1'b0;
      end else if (dbg_cmd || (hit && pfx_set_i)) begin
        pend_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      debug_mode_o  <= 1'b0;
      break_entry_o <= 1'b0;
    end else if (clk_en_i) begin
      break_entry_o <= enter;
      if (enter) begin
        debug_mode_o <= 1'b1;
      end else if (dbg_return_i) begin
        debug_mode_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_wr_bp0;
    upd && cmd_q == CMD_HI && op_q == OP_WR_BP0;
  endsequence

  a_bp_wr_word: assert property (
    s_wr_bp0 |=> bp_q[0] == $past(wr_word))
    else $error("breakpoint 0 write lost");

  a_bp_tlr_ones: assert property (
    tlr |=> bp_q[0] == BP_RESET && bp_q[5] == BP_RESET)
    else $error("breakpoints not all ones after TLR");

  a_status_dbg: assert property (
    tck_rise && tap_st == TAP_CAP_DR && debug_mode_o
    |=> dr_q[DR_ST_MSB:0] == ST_DBG_IDLE)
    else $error("debug status code not captured");

  a_dme_gate: assert property (
    enter |-> pend_q || debug_mode_enable_bit)
    else $error("break entered with compare disabled");

  a_pc_break: assert property (
    clk_en_i && insn_done_i && debug_mode_enable_bit && !debug_mode_o && !pfx_set_i &&
    prog_addr_i == bp_q[0] |=> debug_mode_o && break_entry_o)
    else $error("program address match missed");

  a_pfx_hold: assert property (
    clk_en_i && insn_done_i && pfx_set_i && !debug_mode_o
    |=> !break_entry_o)
    else $error("break split a prefixed pair");

  a_dbg_ignore: assert property (
    debug_mode_o ##1 debug_mode_o |-> !break_entry_o)
    else $error("entry pulse while already in debug");

  a_mask_free: assert property (
    clk_en_i && insn_done_i && debug_mode_enable_bit && register_break_select && !debug_mode_o &&
    !pfx_set_i && dst_wr_i && debug_address_mask_register_q == '0 &&
    bp_q[5][REG_IDX_MSB:0] == dst_reg |=> debug_mode_o)
    else $error("register break with empty mask missed");

  a_entry_level: assert property (
    break_entry_o |-> debug_mode_o ##1 !break_entry_o)
    else $error("entry pulse without debug mode");

endmodule
`default_nettype wire

/* verification/dbc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// Link host: drives the serial link, link clock stands still between frames.
module dbc_host_model (
  output logic      tck_o, // Link clock.
  output logic      tms_o, // Mode select.
  output logic      tdi_o, // Data to the device.
  input  wire logic tdo_i  // Data from the device.
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // Sets up on the low phase and samples just before the rise.
  task automatic tick(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #62.5;
    q = tdo_i;
    tck_o = 1'b1;
    #62.5;
    tck_o = 1'b0;
  endtask

  // Five high mode bits reach Test-Logic-Reset from any state.
  task automatic tap_reset();
    logic q;
    repeat (5) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask

  // One scan, LSB first; the word is read back as it leaves.
  task automatic scan(input logic ir, input logic [9:0] din, input int n,
                      output logic [9:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b0, q);
    if (ir) begin
      tick(1'b1, 1'b0, q);
    end
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, ~tdi_o, q);
    tick(1'b0, ~tdi_o, q);
    // A released data line must not keep showing its last bit.
    tdi_o = ~tdi_o;
  endtask
endmodule
`default_nettype wire

/* verification/debug_breakpoint_compare_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module debug_breakpoint_compare_tb_top;
  import dbc_pkg::*;
  logic        ref_clk_i    = 1'b0;
  logic        sys_rst_i    = 1'b1;
  logic        clk_en_i     = 1'b1;
  logic        insn_done_i  = 1'b0;
  logic        pfx_set_i    = 1'b0;
  logic [15:0] prog_addr_i  = 16'h0100;
  logic        dmem_acc_i   = 1'b1;
  logic [15:0] dmem_addr_i  = 16'h0200;
  logic        dst_wr_i     = 1'b1;
  logic [3:0]  dst_mod_i    = 4'h0;
  logic [4:0]  dst_idx_i    = 5'h00;
  logic [15:0] dst_data_i   = 16'h0000;
  logic        dbg_return_i = 1'b0;
  logic        debug_mode_o;
  logic        break_entry_o;
  wire         tck_w;
  wire         tms_w;
  wire         tdi_w;
  wire         tdo_w;
  int          num_errors   = 0;
  int          n_compared   = 0;
  logic [15:0] bpv [0:5] = '{16'h1234, 16'h2345, 16'h3456, 16'h4567,
                             16'h5A5A, 16'hA5A5};

  always #4 ref_clk_i = ~ref_clk_i;

  dbc_top DUT (
    .ref_clk_i     (ref_clk_i),
    .sys_rst_i     (sys_rst_i),
    .clk_en_i      (clk_en_i),
    .tck_i         (tck_w),
    .tms_i         (tms_w),
    .tdi_i         (tdi_w),
    .tdo_o         (tdo_w),
    .insn_done_i   (insn_done_i),
    .pfx_set_i     (pfx_set_i),
    .prog_addr_i   (prog_addr_i),
    .dmem_acc_i    (dmem_acc_i),
    .dmem_addr_i   (dmem_addr_i),
    .dst_wr_i      (dst_wr_i),
    .dst_mod_i     (dst_mod_i),
    .dst_idx_i     (dst_idx_i),
    .dst_data_i    (dst_data_i),
    .dbg_return_i  (dbg_return_i),
    .debug_mode_o  (debug_mode_o),
    .break_entry_o (break_entry_o)
  );

  dbc_host_model host (
    .tck_o (tck_w),
    .tms_o (tms_w),
    .tdi_o (tdi_w),
    .tdo_i (tdo_w)
  );

  // =====================================================================
  // Checking and access tasks
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask

  task automatic dr(input logic [7:0] b, output logic [9:0] w);
    host.scan(1'b0, {b, 2'b00}, 10, w);
  endtask

  task automatic st(input logic [1:0] e);
    logic [9:0] w;
    dr(8'h00, w);
    chk("status", {14'h0, e}, {14'h0, w[1:0]});
  endtask

  task automatic ctl(input logic [7:0] b);
    logic [9:0] w;
    dr(OP_WR_DEBUG_CONTROL_REGISTER, w);
    dr(b, w);
  endtask

  task automatic wr16(input logic [7:0] op, input logic [15:0] v);
    logic [9:0] w;
    dr(op, w);
    dr(v[7:0], w);
    dr(v[15:8], w);
  endtask

  task automatic rd16(input logic [7:0] op, output logic [15:0] v);
    logic [9:0] w;
    dr(op, w);
    dr(8'h00, w);
    v[7:0] = w[9:2];
    dr(8'h00, w);
    v[15:8] = w[9:2];
  endtask

  task automatic ir_debug();
    logic [9:0] w;
    host.scan(1'b1, {7'h00, IR_DEBUG}, 3, w);
  endtask

  task automatic insn(input logic [15:0] pa, input logic pf,
                      input logic [15:0] da, input logic [8:0] dst,
                      input logic [15:0] dd, input logic ex);
    @(posedge ref_clk_i);
    prog_addr_i <= pa;
    pfx_set_i   <= pf;
    dmem_addr_i <= da;
    dst_idx_i   <= dst[8:4];
    dst_mod_i   <= dst[3:0];
    dst_data_i  <= dd;
    insn_done_i <= 1'b1;
    @(posedge ref_clk_i);
    insn_done_i <= 1'b0;
    #1;
    chk("break_entry", {15'h0, ex}, {15'h0, break_entry_o});
  endtask

  task automatic ret();
    @(posedge ref_clk_i);
    dbg_return_i <= 1'b1;
    @(posedge ref_clk_i);
    dbg_return_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk("debug_mode", 16'h0, {15'h0, debug_mode_o});
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // A hung link or handshake still ends in the closing report.
  initial begin
    repeat (50000) @(posedge ref_clk_i);
    num_errors++;
    print_verdict();
  end

  // =====================================================================
  // Main sequence
  initial begin
    logic [15:0] v;
    repeat (16) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    host.tap_reset();
    ir_debug();
    for (int n = 0; n < 6; n++) begin
      rd16(OP_RD_BP0 + 8'(n), v);
      chk("bp_reset", BP_RESET, v);
      wr16(OP_WR_BP0 + 8'(n), bpv[n]);
      rd16(OP_RD_BP0 + 8'(n), v);
      chk("bp_readback", bpv[n], v);
    end
    insn(bpv[0], 1'b0, bpv[4], 9'h000, 16'h0, 1'b0);
    ctl(8'h20);
    for (int n = 0; n < 6; n++) begin
      if (n < 4) begin
        insn(bpv[n], 1'b0, 16'h0200, 9'h000, 16'h0, 1'b1);
      end else begin
        insn(16'h0100, 1'b0, bpv[n], 9'h000, 16'h0, 1'b1);
      end
      st(2'b01);
      ret();
      st(2'b00);
    end
    insn(16'h1235, 1'b0, 16'h5A5B, 9'h000, 16'h0, 1'b0);
    // A frozen block must not act on a match; a data break needs an access.
    @(posedge ref_clk_i);
    clk_en_i   <= 1'b0;
    dmem_acc_i <= 1'b0;
    insn(bpv[0], 1'b0, 16'h0200, 9'h000, 16'h0, 1'b0);
    @(posedge ref_clk_i);
    clk_en_i   <= 1'b1;
    insn(16'h0100, 1'b0, bpv[4], 9'h000, 16'h0, 1'b0);
    @(posedge ref_clk_i);
    dmem_acc_i <= 1'b1;
    insn(bpv[0], 1'b1, 16'h0200, 9'h000, 16'h0, 1'b0);
    insn(16'h0100, 1'b0, 16'h0200, 9'h000, 16'h0, 1'b1);
    ret();
    // Register compare: reserved upper bits left set on purpose.
    ctl(8'h28);
    wr16(OP_WR_BP0 + 8'h04, 16'hFE79);
    wr16(OP_WR_BP0 + 8'h05, 16'h0123);
    insn(16'h0100, 1'b0, 16'h0200, 9'h079, 16'h0, 1'b1);
    ret();
    insn(16'h0100, 1'b0, 16'hFE79, 9'h07A, 16'h0, 1'b0);
    insn(16'h0100, 1'b0, 16'h0200, 9'h0F9, 16'h0, 1'b0);
    @(posedge ref_clk_i);
    dst_wr_i <= 1'b0;
    insn(16'h0100, 1'b0, 16'h0200, 9'h079, 16'h0, 1'b0);
    @(posedge ref_clk_i);
    dst_wr_i <= 1'b1;
    insn(16'h0100, 1'b0, 16'h0200, 9'h123, 16'hBEEF, 1'b1);
    ret();
    wr16(OP_WR_DEBUG_ADDRESS_MASK_REGISTER, 16'h00FF);
    wr16(OP_WR_DEBUG_DATA_REGISTER, 16'h0012);
    insn(16'h0100, 1'b0, 16'h0200, 9'h123, 16'h3412, 1'b1);
    ret();
    insn(16'h0100, 1'b0, 16'h0200, 9'h123, 16'h3413, 1'b0);
    dr(OP_DEBUG, v[9:0]);
    insn(16'h0100, 1'b0, 16'h0200, 9'h000, 16'h0, 1'b1);
    insn(bpv[0], 1'b0, 16'h0200, 9'h000, 16'h0, 1'b0);
    dr(OP_DEBUG, v[9:0]);
    ret();
    insn(16'h0100, 1'b0, 16'h0200, 9'h000, 16'h0, 1'b0);
    host.tap_reset();
    ir_debug();
    rd16(OP_RD_BP0, v);
    chk("bp0_tlr", BP_RESET, v);
    rd16(OP_RD_BP0 + 8'h05, v);
    chk("bp5_tlr", BP_RESET, v);
    print_verdict();
  end
endmodule
`default_nettype wire
